// *** hw/monitor_gate_pkg.sv ***
// Constants and state types shared by the monitor entry gate
package monitor_gate_pkg;
	localparam logic [7:0]  OP_RUN       = 8'h28;
	localparam logic [7:0]  OP_READ_SP   = 8'h0C;
	localparam logic [3:0]  SEC_COUNT    = 4'h8;
	localparam logic [15:0] SEC_BASE     = 16'hFFF6;
	localparam logic [15:0] SEC_TOP      = 16'hFFFD;
	localparam logic [15:0] STATUS_ADDR  = 16'h0080;
	localparam int          STATUS_BIT   = 6;
	localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
	localparam logic [7:0]  INVALID_BYTE = 8'h00;
	localparam logic [15:0] SP_READ_OFS  = 16'h0001;
	localparam logic [15:0] OFS_PCH      = 16'h0005;
	localparam logic [15:0] OFS_PCL      = 16'h0006;
	localparam logic [2:0]  FRAME_LAST   = 3'h5;
	localparam logic [15:0] SP_RESET     = 16'h00FF;

	typedef enum logic [3:0] {
		G_WAIT_SEC = 4'h0,
		G_PUSH     = 4'h1,
		G_PUSH_W   = 4'h2,
		G_STAT_RD  = 4'h3,
		G_STAT_WR  = 4'h4,
		G_BREAK    = 4'h5,
		G_CMD      = 4'h6,
		G_SP_HI    = 4'h7,
		G_SP_LO    = 4'h8,
		G_POP      = 4'h9,
		G_POP_W    = 4'hA,
		G_RUNNING  = 4'hB
	} gate_state_e;

	typedef enum logic [1:0] {
		STK_IDLE = 2'h0,
		STK_PUSH = 2'h1,
		STK_RD   = 2'h2,
		STK_CAP  = 2'h3
	} stk_state_e;
endpackage

// *** hw/monitor_security_gate.sv ***
// Monitor entry gate: security check, break, run and stack pointer read
// Behaviour
// - On monitor entry the registers are stacked as for a software interrupt, then H is pushed.
// - The run command 0x28 pops H and returns from interrupt to the stacked program counter.
// - The stack pointer read command answers with the stack pointer plus one.
// - The entry frame holds the program counter high byte at SP+5 and the low byte at SP+6.
// - The host sends eight bytes and access opens only if all equal stored bytes 0xFFF6-0xFFFD.
// - After power-on reset the link waits for the eight security bytes before anything else.
// - An opened gate stays open, allowing flash reads and fetches, until the next power-on reset.
// - Any other reset keeps the gate state and asks for no security bytes.
// - On mismatch monitor mode stays, flash reads give an invalid value, fetches cause a reset.
// - After power-on reset the break character goes out only after all eight security bytes have arrived.
// - Bit 6 of RAM byte 0x80 is set when the security bytes matched.
// - A mass erase leaves all eight security bytes at 0xFF.
`timescale 1ns/1ps
`default_nettype none
module monitor_security_gate (
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	input  wire logic        POWER_ON,
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        TX_READY,
	output logic             TX_VALID,
	output logic [7:0]       TX_DATA,
	output logic             TX_BREAK,
	output logic             RAM_REQ,
	output logic             RAM_WE,
	output logic [15:0]      RAM_ADDR,
	output logic [7:0]       RAM_WDATA,
	input  wire logic [7:0]  RAM_RDATA,
	input  wire logic [15:0] CPU_SP,
	input  wire logic [15:0] CPU_PC,
	input  wire logic [7:0]  CPU_A,
	input  wire logic [7:0]  CPU_X,
	input  wire logic [7:0]  CPU_H,
	input  wire logic [7:0]  CPU_CCR,
	output logic             RESUME,
	output logic [15:0]      RESUME_PC,
	output logic [15:0]      RESUME_SP,
	output logic [7:0]       RESUME_A,
	output logic [7:0]       RESUME_X,
	output logic [7:0]       RESUME_H,
	output logic [7:0]       RESUME_CCR,
	input  wire logic        NVM_WE,
	input  wire logic [15:0] NVM_ADDR,
	input  wire logic [7:0]  NVM_WDATA,
	input  wire logic        MASS_ERASE,
	input  wire logic        FLASH_READ,
	input  wire logic [7:0]  FLASH_RDATA,
	input  wire logic        FLASH_FETCH,
	output logic [7:0]       FLASH_DATA_OUT,
	output logic             ILLEGAL_ADDR_RESET,
	output logic             ACCESS_GRANTED
);
	monitor_gate_pkg::gate_state_e state_r;
	monitor_gate_pkg::gate_state_e state_nxt;

	logic        granted_r;
	logic        granted_nxt;
	logic        tx_valid_r;
	logic        tx_valid_nxt;
	logic [7:0]  tx_data_r;
	logic [7:0]  tx_data_nxt;
	logic        tx_break_r;
	logic        tx_break_nxt;
	logic        own_req_r;
	logic        own_req_nxt;
	logic        own_we_r;
	logic        own_we_nxt;
	logic [7:0]  own_wdata_r;
	logic [7:0]  own_wdata_nxt;
	logic [7:0]  sp_lo_r;
	logic [7:0]  sp_lo_nxt;
	logic        resume_r;
	logic        resume_nxt;
	logic [7:0]  flash_q_r;
	logic [7:0]  flash_q_nxt;
	logic        illegal_r;
	logic        illegal_nxt;

	logic        start_push;
	logic        start_pop;
	logic        stk_done;
	logic        sec_done;
	logic        sec_match;
	logic        sec_byte;
	logic [15:0] stk_sp;
	logic [15:0] sp_read;

	stack_mem_if mem ();

	// Only security bytes may reach the comparator, never later commands
	assign sec_byte   = RX_VALID && state_r == monitor_gate_pkg::G_WAIT_SEC;
	assign start_push = state_r == monitor_gate_pkg::G_PUSH;
	assign start_pop  = state_r == monitor_gate_pkg::G_POP;
	assign sp_read    = stk_sp + monitor_gate_pkg::SP_READ_OFS;

	security_compare u_compare (
		.clk        (CLOCK),
		.rst        (RESET),
		.byte_valid (sec_byte),
		.byte_data  (RX_DATA),
		.prog_we    (NVM_WE),
		.prog_addr  (NVM_ADDR),
		.prog_data  (NVM_WDATA),
		.mass_erase (MASS_ERASE),
		.count_done (sec_done),
		.matched    (sec_match)
	);

	stack_engine u_stack (
		.clk        (CLOCK),
		.rst        (RESET),
		.start_push (start_push),
		.start_pop  (start_pop),
		.sp_in      (CPU_SP),
		.pc_in      (CPU_PC),
		.a_in       (CPU_A),
		.x_in       (CPU_X),
		.h_in       (CPU_H),
		.ccr_in     (CPU_CCR),
		.mem        (mem.engine),
		.done       (stk_done),
		.sp_out     (stk_sp),
		.pc_out     (RESUME_PC),
		.a_out      (RESUME_A),
		.x_out      (RESUME_X),
		.h_out      (RESUME_H),
		.ccr_out    (RESUME_CCR)
	);

	// The gate owns the RAM port only for the status byte update
	assign mem.rdata = RAM_RDATA;
	assign RAM_REQ   = own_req_r | mem.req;
	assign RAM_WE    = own_req_r ? own_we_r : mem.we;
	assign RAM_ADDR  = own_req_r ? monitor_gate_pkg::STATUS_ADDR : mem.addr;
	assign RAM_WDATA = own_req_r ? own_wdata_r : mem.wdata;

	assign TX_VALID           = tx_valid_r;
	assign TX_DATA            = tx_data_r;
	assign TX_BREAK           = tx_break_r;
	assign RESUME             = resume_r;
	assign RESUME_SP          = stk_sp;
	assign FLASH_DATA_OUT     = flash_q_r;
	assign ILLEGAL_ADDR_RESET = illegal_r;
	assign ACCESS_GRANTED     = granted_r;

	always_comb begin
		state_nxt     = state_r;
		granted_nxt   = granted_r;
		tx_valid_nxt  = tx_valid_r;
		tx_data_nxt   = tx_data_r;
		tx_break_nxt  = tx_break_r;
		own_req_nxt   = 1'b0;
		own_we_nxt    = 1'b0;
		own_wdata_nxt = own_wdata_r;
		sp_lo_nxt     = sp_lo_r;
		resume_nxt    = 1'b0;
		unique case (state_r)
			monitor_gate_pkg::G_WAIT_SEC: begin
				// Nothing is sent until the eighth byte is in
				if (sec_done) begin
					granted_nxt = granted_r | sec_match;
					state_nxt = monitor_gate_pkg::G_PUSH;
				end
			end
			monitor_gate_pkg::G_PUSH: begin
				state_nxt = monitor_gate_pkg::G_PUSH_W;
			end
			monitor_gate_pkg::G_PUSH_W: begin
				if (stk_done) begin
					own_req_nxt = 1'b1;
					state_nxt = monitor_gate_pkg::G_STAT_RD;
				end
			end
			monitor_gate_pkg::G_STAT_RD: begin
				// Read-modify-write keeps the other bits of the status byte
				state_nxt = monitor_gate_pkg::G_STAT_WR;
			end
			monitor_gate_pkg::G_STAT_WR: begin
				own_wdata_nxt = RAM_RDATA;
				own_wdata_nxt[monitor_gate_pkg::STATUS_BIT] = granted_r;
				own_req_nxt = 1'b1;
				own_we_nxt = 1'b1;
				tx_break_nxt = 1'b1;
				state_nxt = monitor_gate_pkg::G_BREAK;
			end
			monitor_gate_pkg::G_BREAK: begin
				if (TX_READY) begin
					tx_break_nxt = 1'b0;
					state_nxt = monitor_gate_pkg::G_CMD;
				end
			end
			monitor_gate_pkg::G_CMD: begin
				// Unknown opcodes are dropped; their handling lives elsewhere
				if (RX_VALID && RX_DATA == monitor_gate_pkg::OP_RUN) begin
					state_nxt = monitor_gate_pkg::G_POP;
				end else if (RX_VALID && RX_DATA == monitor_gate_pkg::OP_READ_SP) begin
					tx_valid_nxt = 1'b1;
					tx_data_nxt = sp_read[15:8];
					sp_lo_nxt = sp_read[7:0];
					state_nxt = monitor_gate_pkg::G_SP_HI;
				end
			end
			monitor_gate_pkg::G_SP_HI: begin
				if (TX_READY) begin
					tx_data_nxt = sp_lo_r;
					state_nxt = monitor_gate_pkg::G_SP_LO;
				end
			end
			monitor_gate_pkg::G_SP_LO: begin
				if (TX_READY) begin
					tx_valid_nxt = 1'b0;
					state_nxt = monitor_gate_pkg::G_CMD;
				end
			end
			monitor_gate_pkg::G_POP: begin
				state_nxt = monitor_gate_pkg::G_POP_W;
			end
			monitor_gate_pkg::G_POP_W: begin
				if (stk_done) begin
					resume_nxt = 1'b1;
					state_nxt = monitor_gate_pkg::G_RUNNING;
				end
			end
			monitor_gate_pkg::G_RUNNING: begin
				state_nxt = monitor_gate_pkg::G_RUNNING;
			end
			default: begin
				state_nxt = monitor_gate_pkg::G_CMD;
			end
		endcase
	end

	// Flash gating stays active in every state, the monitor included
	always_comb begin
		flash_q_nxt = flash_q_r;
		illegal_nxt = 1'b0;
		if (FLASH_READ) begin
			flash_q_nxt = granted_r ? FLASH_RDATA : monitor_gate_pkg::INVALID_BYTE;
		end
		if (FLASH_FETCH && !granted_r) begin
			illegal_nxt = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			// Only a power-on reset asks for the bytes again
			state_r <= POWER_ON ? monitor_gate_pkg::G_WAIT_SEC
				: monitor_gate_pkg::G_PUSH;
			tx_valid_r  <= 1'b0;
			tx_data_r   <= 8'h00;
			tx_break_r  <= 1'b0;
			own_req_r   <= 1'b0;
			own_we_r    <= 1'b0;
			own_wdata_r <= 8'h00;
			sp_lo_r     <= 8'h00;
			resume_r    <= 1'b0;
			flash_q_r   <= 8'h00;
			illegal_r   <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			tx_valid_r  <= tx_valid_nxt;
			tx_data_r   <= tx_data_nxt;
			tx_break_r  <= tx_break_nxt;
			own_req_r   <= own_req_nxt;
			own_we_r    <= own_we_nxt;
			own_wdata_r <= own_wdata_nxt;
			sp_lo_r     <= sp_lo_nxt;
			resume_r    <= resume_nxt;
			flash_q_r   <= flash_q_nxt;
			illegal_r   <= illegal_nxt;
		end
	end

	// Survives a warm reset; a power-on reset closes it
	always_ff @(posedge CLOCK) begin
		if (RESET && POWER_ON) begin
			granted_r <= 1'b0;
		end else if (RESET) begin
			granted_r <= granted_r;
		end else begin
			granted_r <= granted_nxt;
		end
	end
endmodule
`default_nettype wire

// *** hw/security_compare.sv ***
// Eight stored security bytes and in-order comparison of received bytes
`timescale 1ns/1ps
`default_nettype none
module security_compare (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	input  wire logic        prog_we,
	input  wire logic [15:0] prog_addr,
	input  wire logic [7:0]  prog_data,
	input  wire logic        mass_erase,
	output logic             count_done,
	output logic             matched
);
	// Nonvolatile in silicon, so the array is deliberately left out of reset
	logic [7:0] stored_r [0:7];
	logic [7:0] stored_nxt [0:7];
	logic [3:0] idx_r;
	logic [3:0] idx_nxt;
	logic       miss_r;
	logic       miss_nxt;
	logic       in_range;
	logic [15:0] prog_ofs;

	assign prog_ofs   = prog_addr - monitor_gate_pkg::SEC_BASE;
	assign in_range   = prog_addr >= monitor_gate_pkg::SEC_BASE &&
		prog_addr <= monitor_gate_pkg::SEC_TOP;
	assign count_done = idx_r == monitor_gate_pkg::SEC_COUNT;
	assign matched    = count_done && !miss_r;

	always_comb begin
		idx_nxt  = idx_r;
		miss_nxt = miss_r;
		for (int i = 0; i < 8; i++) begin
			if (mass_erase) begin
				stored_nxt[i] = monitor_gate_pkg::ERASED_BYTE;
			end else if (prog_we && in_range && prog_ofs[2:0] == 3'(i)) begin
				stored_nxt[i] = prog_data;
			end else begin
				stored_nxt[i] = stored_r[i];
			end
		end
		if (byte_valid && !count_done) begin
			// Arrival order meets ascending address order
			if (byte_data != stored_r[idx_r[2:0]]) begin
				miss_nxt = 1'b1;
			end
			idx_nxt = idx_r + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		stored_r <= stored_nxt;
		if (rst) begin
			idx_r  <= 4'h0;
			miss_r <= 1'b0;
		end else begin
			idx_r  <= idx_nxt;
			miss_r <= miss_nxt;
		end
	end
endmodule
`default_nettype wire

// *** hw/stack_engine.sv ***
// Pushes the monitor entry frame and pops it back for the run command
`timescale 1ns/1ps
`default_nettype none
module stack_engine (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start_push,
	input  wire logic        start_pop,
	input  wire logic [15:0] sp_in,
	input  wire logic [15:0] pc_in,
	input  wire logic [7:0]  a_in,
	input  wire logic [7:0]  x_in,
	input  wire logic [7:0]  h_in,
	input  wire logic [7:0]  ccr_in,
	stack_mem_if.engine      mem,
	output logic             done,
	output logic [15:0]      sp_out,
	output logic [15:0]      pc_out,
	output logic [7:0]       a_out,
	output logic [7:0]       x_out,
	output logic [7:0]       h_out,
	output logic [7:0]       ccr_out
);
	monitor_gate_pkg::stk_state_e state_r, state_nxt;
	logic [2:0]  step_r, step_nxt;
	logic [15:0] sp_r, sp_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [7:0]  a_r, a_nxt;
	logic [7:0]  x_r, x_nxt;
	logic [7:0]  h_r, h_nxt;
	logic [7:0]  ccr_r, ccr_nxt;
	logic        done_r, done_nxt;

	// Interrupt stacking order, then the index high byte last
	// Values come in as arguments, so the continuous assign follows every change of them
	function automatic logic [7:0] push_byte(
		input logic [2:0]  s,
		input logic [15:0] pc,
		input logic [7:0]  x,
		input logic [7:0]  a,
		input logic [7:0]  ccr,
		input logic [7:0]  h
	);
		case (s)
			3'h0:    push_byte = pc[7:0];
			3'h1:    push_byte = pc[15:8];
			3'h2:    push_byte = x;
			3'h3:    push_byte = a;
			3'h4:    push_byte = ccr;
			default: push_byte = h;
		endcase
	endfunction

	assign mem.req   = state_r == monitor_gate_pkg::STK_PUSH ||
		state_r == monitor_gate_pkg::STK_RD;
	assign mem.we    = state_r == monitor_gate_pkg::STK_PUSH;
	assign mem.addr  = mem.we ? sp_r : sp_r + 16'h0001;
	assign mem.wdata = push_byte(step_r, pc_r, x_r, a_r, ccr_r, h_r);
	assign done    = done_r;
	assign sp_out  = sp_r;
	assign pc_out  = pc_r;
	assign a_out   = a_r;
	assign x_out   = x_r;
	assign h_out   = h_r;
	assign ccr_out = ccr_r;

	always_comb begin
		state_nxt = state_r;
		step_nxt  = step_r;
		sp_nxt    = sp_r;
		pc_nxt    = pc_r;
		a_nxt     = a_r;
		x_nxt     = x_r;
		h_nxt     = h_r;
		ccr_nxt   = ccr_r;
		done_nxt  = 1'b0;
		unique case (state_r)
			monitor_gate_pkg::STK_IDLE: begin
				step_nxt = 3'h0;
				if (start_push) begin
					sp_nxt = sp_in;
					pc_nxt = pc_in;
					a_nxt = a_in;
					x_nxt = x_in;
					h_nxt = h_in;
					ccr_nxt = ccr_in;
					state_nxt = monitor_gate_pkg::STK_PUSH;
				end else if (start_pop) begin
					state_nxt = monitor_gate_pkg::STK_RD;
				end
			end
			monitor_gate_pkg::STK_PUSH: begin
				// PCH lands at SP+5 and PCL at SP+6 once H is on top
				sp_nxt = sp_r - 16'h0001;
				step_nxt = step_r + 3'h1;
				if (step_r == monitor_gate_pkg::FRAME_LAST) begin
					done_nxt = 1'b1;
					state_nxt = monitor_gate_pkg::STK_IDLE;
				end
			end
			monitor_gate_pkg::STK_RD: begin
				sp_nxt = sp_r + 16'h0001;
				state_nxt = monitor_gate_pkg::STK_CAP;
			end
			monitor_gate_pkg::STK_CAP: begin
				// Host edits of the frame are picked up here
				case (step_r)
					3'h0:    h_nxt = mem.rdata;
					3'h1:    ccr_nxt = mem.rdata;
					3'h2:    a_nxt = mem.rdata;
					3'h3:    x_nxt = mem.rdata;
					3'h4:    pc_nxt = {mem.rdata, pc_r[7:0]};
					default: pc_nxt = {pc_r[15:8], mem.rdata};
				endcase
				step_nxt = step_r + 3'h1;
				state_nxt = monitor_gate_pkg::STK_RD;
				if (step_r == monitor_gate_pkg::FRAME_LAST) begin
					done_nxt = 1'b1;
					state_nxt = monitor_gate_pkg::STK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= monitor_gate_pkg::STK_IDLE;
			step_r  <= 3'h0;
			sp_r    <= monitor_gate_pkg::SP_RESET;
			pc_r    <= 16'h0000;
			a_r     <= 8'h00;
			x_r     <= 8'h00;
			h_r     <= 8'h00;
			ccr_r   <= 8'h00;
			done_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			step_r  <= step_nxt;
			sp_r    <= sp_nxt;
			pc_r    <= pc_nxt;
			a_r     <= a_nxt;
			x_r     <= x_nxt;
			h_r     <= h_nxt;
			ccr_r   <= ccr_nxt;
			done_r  <= done_nxt;
		end
	end
endmodule
`default_nettype wire

// *** hw/stack_mem_if.sv ***
// RAM request path from the stack engine to the gate's RAM port
`timescale 1ns/1ps
`default_nettype none
interface stack_mem_if;
	logic        req;
	logic        we;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;

	modport engine (output req, output we, output addr, output wdata, input rdata);
	modport owner  (input req, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** sim/gate_sva.sv ***
// Port checker for the monitor entry gate
`timescale 1ns/1ps
`default_nettype none
module gate_sva (
	input wire logic        CLOCK,
	input wire logic        RESET,
	input wire logic        POWER_ON,
	input wire logic        RX_VALID,
	input wire logic        TX_VALID,
	input wire logic [7:0]  TX_DATA,
	input wire logic        TX_BREAK,
	input wire logic        RAM_REQ,
	input wire logic        RAM_WE,
	input wire logic [15:0] RAM_ADDR,
	input wire logic [7:0]  RAM_WDATA,
	input wire logic [7:0]  RAM_RDATA,
	input wire logic        RESUME,
	input wire logic [15:0] RESUME_PC,
	input wire logic        FLASH_READ,
	input wire logic [7:0]  FLASH_RDATA,
	input wire logic        FLASH_FETCH,
	input wire logic [7:0]  FLASH_DATA_OUT,
	input wire logic        ILLEGAL_ADDR_RESET,
	input wire logic        ACCESS_GRANTED
);
	logic [3:0]  cnt_r, cnt_nxt;
	logic [15:0] top_r, top_nxt, ra_r, ra_nxt, pc_r, pc_nxt;
	logic        rd_r, rd_nxt;

	// A non power-on reset needs no bytes, so it counts as all eight seen
	always_comb begin
		cnt_nxt = cnt_r;
		if (RESET)
			cnt_nxt = POWER_ON ? 4'h0 : 4'h8;
		else if (RX_VALID && cnt_r != 4'h8)
			cnt_nxt = cnt_r + 4'h1;
		top_nxt = top_r;
		if (RAM_REQ && RAM_WE && RAM_ADDR != monitor_gate_pkg::STATUS_ADDR)
			top_nxt = RAM_ADDR;
		rd_nxt = RAM_REQ && !RAM_WE;
		ra_nxt = RAM_ADDR;
		pc_nxt = pc_r;
		if (rd_r && ra_r == top_r + 16'h4)
			pc_nxt[15:8] = RAM_RDATA;
		if (rd_r && ra_r == top_r + 16'h5)
			pc_nxt[7:0] = RAM_RDATA;
	end

	always_ff @(posedge CLOCK) begin
		cnt_r <= cnt_nxt;
		top_r <= top_nxt;
		rd_r  <= rd_nxt;
		ra_r  <= ra_nxt;
		pc_r  <= pc_nxt;
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	sequence stat_rd;
		RAM_REQ && !RAM_WE && RAM_ADDR == monitor_gate_pkg::STATUS_ADDR;
	endsequence
	sequence stat_wr;
		RAM_REQ && RAM_WE && RAM_ADDR == monitor_gate_pkg::STATUS_ADDR
			&& RAM_WDATA[monitor_gate_pkg::STATUS_BIT] == ACCESS_GRANTED;
	endsequence

	brk_after_bytes_a: assert property (TX_BREAK |-> cnt_r == 4'h8)
		else $error("break before eight security bytes");
	stat_bit_a: assert property (stat_rd |-> ##[1:2] stat_wr)
		else $error("status bit not written with grant");
	sp_read_a: assert property ($rose(TX_VALID) |-> TX_DATA == top_r[15:8])
		else $error("stack pointer answer wrong");
	resume_pc_a: assert property (RESUME |-> RESUME_PC == pc_r)
		else $error("resume address not from frame");
	flash_invalid_a: assert property (FLASH_READ && !ACCESS_GRANTED |=>
		FLASH_DATA_OUT == monitor_gate_pkg::INVALID_BYTE)
		else $error("closed flash read leaked data");
	flash_open_a: assert property (FLASH_READ && ACCESS_GRANTED |=>
		FLASH_DATA_OUT == $past(FLASH_RDATA))
		else $error("open flash read wrong");
	fetch_gate_a: assert property (FLASH_FETCH |=>
		ILLEGAL_ADDR_RESET == !$past(ACCESS_GRANTED))
		else $error("fetch reset wrong");
	grant_hold_a: assert property (disable iff (RESET && POWER_ON)
		ACCESS_GRANTED |=> ACCESS_GRANTED)
		else $error("grant lost without power-on reset");
	pon_clear_a: assert property (disable iff (1'b0)
		RESET && POWER_ON |=> !ACCESS_GRANTED)
		else $error("grant survived power-on reset");
endmodule

bind monitor_security_gate gate_sva gate_sva_inst (.CLOCK, .RESET, .POWER_ON, .RX_VALID,
	.TX_VALID, .TX_DATA, .TX_BREAK, .RAM_REQ, .RAM_WE, .RAM_ADDR, .RAM_WDATA, .RAM_RDATA,
	.RESUME, .RESUME_PC, .FLASH_READ, .FLASH_RDATA, .FLASH_FETCH, .FLASH_DATA_OUT,
	.ILLEGAL_ADDR_RESET, .ACCESS_GRANTED);
`default_nettype wire

// *** sim/ram_model.sv ***
// Behavioural RAM that answers the gate's stack and status accesses
`timescale 1ns/1ps
`default_nettype none
module ram_model (
	input  wire logic        CLOCK,
	input  wire logic        RAM_REQ,
	input  wire logic        RAM_WE,
	input  wire logic [15:0] RAM_ADDR,
	input  wire logic [7:0]  RAM_WDATA,
	output var  logic [7:0]  RAM_RDATA
);
	logic [7:0] mem [0:65535];

	initial RAM_RDATA = 8'h5A;

	// Read data is good only in the cycle after a read; otherwise it toggles so stale use shows
	always @(posedge CLOCK) begin
		if (RAM_REQ && RAM_WE)
			mem[RAM_ADDR] <= RAM_WDATA;
		RAM_RDATA <= (RAM_REQ && !RAM_WE) ? mem[RAM_ADDR] : ~RAM_RDATA;
	end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the monitor entry gate
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        CLOCK, RESET, POWER_ON, RX_VALID, TX_READY, TX_VALID, TX_BREAK;
	logic        RAM_REQ, RAM_WE, RESUME, NVM_WE, MASS_ERASE, FLASH_READ, FLASH_FETCH;
	logic        ILLEGAL_ADDR_RESET, ACCESS_GRANTED;
	logic [7:0]  RX_DATA, TX_DATA, RAM_WDATA, RAM_RDATA, CPU_A, CPU_X, CPU_H, CPU_CCR;
	logic [7:0]  RESUME_A, RESUME_X, RESUME_H, RESUME_CCR, NVM_WDATA, FLASH_RDATA;
	logic [7:0]  FLASH_DATA_OUT;
	logic [15:0] RAM_ADDR, CPU_SP, CPU_PC, RESUME_PC, RESUME_SP, NVM_ADDR;
	logic [31:0] seed = 32'h3C6C;
	logic [31:0] rr, cpu_r;
	logic [7:0]  key [8];
	logic [7:0]  code [8];
	logic [7:0]  q_tx [$];
	logic [8:0]  q_fl [$];
	logic [15:0] q_pc [$];
	logic        fl_d = 1'b0;
	int          n_errors = 0;
	int          num_checks = 0;
	int          n_brk = 0;
	int          brk_exp = 0;

	monitor_security_gate monitor_security_gate_inst (.CLOCK, .RESET, .POWER_ON, .RX_VALID,
		.RX_DATA, .TX_READY, .TX_VALID, .TX_DATA, .TX_BREAK, .RAM_REQ, .RAM_WE, .RAM_ADDR,
		.RAM_WDATA, .RAM_RDATA, .CPU_SP, .CPU_PC, .CPU_A, .CPU_X, .CPU_H, .CPU_CCR, .RESUME,
		.RESUME_PC, .RESUME_SP, .RESUME_A, .RESUME_X, .RESUME_H, .RESUME_CCR, .NVM_WE,
		.NVM_ADDR, .NVM_WDATA, .MASS_ERASE, .FLASH_READ, .FLASH_RDATA, .FLASH_FETCH,
		.FLASH_DATA_OUT, .ILLEGAL_ADDR_RESET, .ACCESS_GRANTED);
	ram_model ram_model_inst (.CLOCK, .RAM_REQ, .RAM_WE, .RAM_ADDR, .RAM_WDATA, .RAM_RDATA);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask

	task automatic send(input logic [7:0] b);
		RX_VALID = 1'b1;
		RX_DATA = b;
		tick(1);
		RX_VALID = 1'b0;
		RX_DATA = ~b;
		tick(1);
	endtask

	task automatic wait_all();
		for (int i = 0; i < 500 && (n_brk < brk_exp || q_tx.size() + q_pc.size() > 0); i++)
			tick(1);
		if (n_brk < brk_exp || q_tx.size() + q_pc.size() > 0) begin
			$display("FAIL %0t wait ran out", $time);
			n_errors++;
			close_out();
		end
	endtask

	task automatic reset_dut(input logic pon);
		RESET = 1'b1;
		POWER_ON = pon;
		tick(16);
		RESET = 1'b0;
		POWER_ON = 1'b0;
		tick(2);
	endtask

	task automatic flash_probe(input logic g);
		logic [31:0] r;
		r = rnd();
		FLASH_READ = 1'b1;
		FLASH_FETCH = 1'b1;
		FLASH_RDATA = r[7:0];
		q_fl.push_back({!g, g ? r[7:0] : monitor_gate_pkg::INVALID_BYTE});
		tick(1);
		FLASH_READ = 1'b0;
		FLASH_FETCH = 1'b0;
		FLASH_RDATA = ~r[7:0];
		tick(2);
	endtask

	task automatic sp_read();
		logic [15:0] e;
		e = CPU_SP - 16'h5;
		q_tx.push_back(e[15:8]);
		q_tx.push_back(e[7:0]);
		send(monitor_gate_pkg::OP_READ_SP);
		wait_all();
	endtask

	task automatic after_brk(input logic g);
		logic [15:0] sp;
		sp = CPU_SP;
		wait_all();
		tick(4);
		check({15'h0000, ACCESS_GRANTED}, {15'h0000, g});
		check({15'h0000, ram_model_inst.mem[16'h0080][6]}, {15'h0000, g});
		check({ram_model_inst.mem[sp - 16'h1], ram_model_inst.mem[sp]}, CPU_PC);
		check({ram_model_inst.mem[sp - 16'h5], ram_model_inst.mem[sp - 16'h2]}, {CPU_H, CPU_X});
		flash_probe(g);
		sp_read();
	endtask

	task automatic enter(input logic g);
		for (int i = 0; i < 7; i++)
			send(code[i]);
		tick(20);
		check(16'(n_brk), 16'(brk_exp));
		send(code[7]);
		brk_exp++;
		after_brk(g);
	endtask

	task automatic run();
		logic [15:0] pc;
		pc = 16'(rnd());
		{ram_model_inst.mem[CPU_SP - 16'h1], ram_model_inst.mem[CPU_SP]} = pc;
		ram_model_inst.mem[CPU_SP - 16'h5] = pc[7:0];
		q_pc.push_back(pc);
		send(monitor_gate_pkg::OP_RUN);
		wait_all();
		tick(1);
		check(RESUME_SP, CPU_SP);
		check({8'h00, RESUME_H}, {8'h00, pc[7:0]});
		check({RESUME_A, RESUME_X}, {CPU_A, CPU_X});
		check({8'h00, RESUME_CCR}, {8'h00, CPU_CCR});
	endtask

	initial begin
		CLOCK = 1'b0;
		forever #12.5 CLOCK = ~CLOCK;
	end

	// Ready drops a quarter of the time, so answers must stand while stalled
	always @(posedge CLOCK) begin
		if (fl_d)
			check({7'h00, ILLEGAL_ADDR_RESET, FLASH_DATA_OUT}, {7'h00, q_fl.pop_front()});
		fl_d = FLASH_READ;
		if (TX_VALID && TX_READY)
			check({8'h00, TX_DATA}, {8'h00, q_tx.pop_front()});
		if (TX_BREAK && TX_READY)
			n_brk++;
		if (RESUME)
			check(RESUME_PC, q_pc.pop_front());
		rr = rnd();
		TX_READY <= #1 rr[0] | rr[1];
	end

	initial begin
		{RX_VALID, RX_DATA, NVM_WE, NVM_ADDR, NVM_WDATA} = '0;
		{MASS_ERASE, FLASH_READ, FLASH_FETCH, FLASH_RDATA} = '0;
		cpu_r = rnd();
		CPU_SP = {8'h00, 2'b11, cpu_r[5:0]};
		CPU_PC = cpu_r[31:16];
		{CPU_A, CPU_X, CPU_H, CPU_CCR} = rnd();
		reset_dut(1'b1);
		for (int i = 0; i < 8; i++) begin
			key[i] = 8'(rnd());
			NVM_WE = 1'b1;
			NVM_ADDR = monitor_gate_pkg::SEC_BASE + 16'(i);
			NVM_WDATA = key[i];
			tick(1);
			NVM_WE = 1'b0;
			tick(1);
		end
		code = key;
		code[7] = ~key[7];
		enter(1'b0);
		run();
		reset_dut(1'b1);
		code = key;
		enter(1'b1);
		reset_dut(1'b0);
		brk_exp++;
		after_brk(1'b1);
		run();
		MASS_ERASE = 1'b1;
		tick(1);
		MASS_ERASE = 1'b0;
		reset_dut(1'b1);
		check({15'h0000, ACCESS_GRANTED}, 16'h0000);
		code = '{default: 8'hFF};
		enter(1'b1);
		close_out();
	end
endmodule
`default_nettype wire
